//--- src/scm_pkg.sv
// Shared constants and types of the system clock mode control block
package scm_pkg;

   // Reference rates; the oscillator rates are nominal, not measured
   localparam int unsigned SYS_CLK_HZ = 40_000_000;
   localparam int unsigned FAST_INT_RC_HZ = 8_000_000;
   localparam int unsigned SLOW_CRYSTAL_HZ = 32_768;
   localparam int unsigned SLOW_INT_RC_HZ = 32_000;

   // Register offsets
   localparam logic [7:0] OFS_MODE_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE_EXT = 8'h01;
   localparam logic [7:0] OFS_LXT_PWR = 8'h02;
   localparam logic [7:0] OFS_STATUS = 8'h03;

   // Field positions
   localparam int unsigned DIV_SEL_HI = 7;
   localparam int unsigned DIV_SEL_LO = 5;
   localparam int unsigned IDLE_EN_BIT = 1;
   localparam int unsigned HL_SEL_BIT = 0;
   localparam int unsigned KEEP_ON_BIT = 7;
   localparam int unsigned LXT_LP_BIT = 0;
   localparam int unsigned STAT_RUN_BIT = 3;

   // Reset values
   localparam logic [7:0] MODE_CTRL_RST = 8'h03;
   localparam logic [7:0] MODE_EXT_RST = 8'h00;
   localparam logic [7:0] LXT_PWR_RST = 8'h00;

   // Divider select codes at or below this pick the substitute clock
   localparam logic [2:0] DIV_SUB_MAX = 3'h1;
   localparam int unsigned FAST_DIV_W = 6;

   // Configuration option encodings
   localparam logic [1:0] CFG_FAST_XTAL = 2'h0;
   localparam logic [1:0] CFG_FAST_EXT_RC = 2'h1;
   localparam logic [1:0] CFG_FAST_INT_RC = 2'h2;
   localparam logic CFG_SLOW_INT_RC = 1'b0;
   localparam logic CFG_SLOW_XTAL = 1'b1;

   // Clock source codes seen by the glitch-free switch
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [3:0] SRC_SUB = 4'h1;
   localparam logic [3:0] SRC_FAST = 4'h2;
   localparam logic SRC_DIV_FLAG = 1'b1;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_SLOW = 3'h1,
      MODE_IDLE_ALL_STOP = 3'h2,
      MODE_IDLE_CLOCK_RUN = 3'h3,
      MODE_SLEEP_ALL_OFF = 3'h4,
      MODE_SLEEP_SUB_ON = 3'h5,
      MODE_WAKE_SUB = 3'h6
   } scm_mode_t;

endpackage : scm_pkg

//--- src/scm_sel_if.sv
// Source request and current source between mode control and switch
`timescale 1ns/1ps
interface scm_sel_if;
   logic [3:0] req_code;
   logic req_lvl;
   logic [3:0] cur_code;
   logic cur_lvl;

   modport ctrl (output req_code, output req_lvl, output cur_lvl,
                 input cur_code);
   modport mux (input req_code, input req_lvl, input cur_lvl,
                output cur_code);
endinterface : scm_sel_if

//--- src/scm_fast_div.sv
// Ripple-free divider of the sampled fast clock, /2 up to /2**W
`timescale 1ns/1ps
module scm_fast_div #(
   parameter int unsigned W = scm_pkg::FAST_DIV_W
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic fast_lvl,
   output logic [W-1:0] div_ff
);
   logic prev_ff;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_ff <= 1'b0;
      end
      else
      begin
         prev_ff <= fast_lvl;
      end
   end

   // Bit k toggles every 2**k fast rising edges, giving fast/2**(k+1)
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_ff <= '0;
      end
      else if (fast_lvl && !prev_ff)
      begin
         div_ff <= div_ff + W'(1);
      end
   end
endmodule : scm_fast_div

//--- src/scm_glitch_mux.sv
// Glitch-free switch between clock source levels
`timescale 1ns/1ps
module scm_glitch_mux (
   input wire logic sys_clk,
   input wire logic rst_n,
   scm_sel_if.mux sel,
   output logic clk_ff
);
   logic [3:0] cur_ff;
   logic park_ff;
   logic park_lvl_ff;
   logic seen_fall_ff;

   assign sel.cur_code = cur_ff;

   // glitch-free hand-over
   // Leave the old source only in its low phase, then hold low through one
   // whole low phase of the new source, so no phase is ever cut short.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_ff <= scm_pkg::SRC_OFF;
         park_ff <= 1'b0;
         park_lvl_ff <= 1'b0;
         seen_fall_ff <= 1'b0;
         clk_ff <= 1'b0;
      end
      else if (park_ff)
      begin
         cur_ff <= sel.req_code;
         clk_ff <= 1'b0;
         park_lvl_ff <= sel.req_lvl && (sel.req_code == cur_ff);
         // A request that moves while parked restarts the wait
         if (sel.req_code != cur_ff)
            seen_fall_ff <= 1'b0;
         else if (park_lvl_ff && !sel.req_lvl)
            seen_fall_ff <= 1'b1;
         else if (seen_fall_ff && sel.req_lvl)
         begin
            park_ff <= 1'b0;
            seen_fall_ff <= 1'b0;
            clk_ff <= 1'b1;
         end
      end
      else if (sel.req_code != cur_ff && !clk_ff && !sel.cur_lvl)
      begin
         cur_ff <= sel.req_code;
         park_ff <= 1'b1;
         park_lvl_ff <= 1'b0;
         seen_fall_ff <= 1'b0;
         clk_ff <= 1'b0;
      end
      else
      begin
         clk_ff <= sel.cur_lvl;
      end
   end
endmodule : scm_glitch_mux

//--- src/scm_top.sv
// System clock source, divider and operating mode control
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module scm_top (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic fast_crystal_osc,
   input wire logic fast_external_rc_osc,
   input wire logic fast_internal_rc_osc,
   input wire logic slow_crystal_osc,
   input wire logic slow_internal_rc_osc,
   input wire logic fast_osc_ready,
   input wire logic [1:0] cfg_fast_src,
   input wire logic cfg_slow_src,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic sub_keep_req,
   output logic system_clock_out,
   output logic sub_clock_out,
   output logic cpu_run,
   output logic [2:0] op_mode,
   output logic [2:0] fast_osc_en,
   output logic slow_crystal_en,
   output logic slow_rc_en,
   output logic slow_crystal_power_sel,
   output logic pb1_gpio_free,
   output logic pb2_gpio_free,
   output logic xt_pins_gpio_free
);
   localparam int unsigned NSYNC = 9;
   localparam int unsigned DW = scm_pkg::FAST_DIV_W;

   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] meta_ff;
   logic [NSYNC-1:0] sync_ff;
   logic fxt_s, ferc_s, firc_s, sxt_s, sirc_s, frdy_s, sslow_s;
   logic [1:0] sfast_s;
   logic fast_lvl, sub_lvl;
   logic [DW-1:0] div_ff;
   logic mux_clk_ff;

   logic [2:0] div_sel_ff;
   logic idle_en_ff, hl_sel_ff, keep_on_ff, lxt_lp_ff;
   scm_pkg::scm_mode_t mode_ff, nxt_mode, run_mode, halt_mode;
   logic [3:0] sel_code, nxt_req;
   logic fast_on, sub_on;

   logic [7:0] rdata_ff;
   logic sys_out_ff, sub_out_ff, cpu_run_ff;
   logic [2:0] fast_en_ff;
   logic sxt_en_ff, sirc_en_ff;
   logic pb1_ff, pb2_ff, xt_free_ff;

   scm_sel_if sel_if ();

   assign async_in = {cfg_slow_src, cfg_fast_src, fast_osc_ready,
                      slow_internal_rc_osc, slow_crystal_osc,
                      fast_internal_rc_osc, fast_external_rc_osc,
                      fast_crystal_osc};

   // Oscillators and option pins are asynchronous to sys_clk
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_ff[gi] <= 1'b0;
               sync_ff[gi] <= 1'b0;
            end
            else
            begin
               meta_ff[gi] <= async_in[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   assign fxt_s = sync_ff[0];
   assign ferc_s = sync_ff[1];
   assign firc_s = sync_ff[2];
   assign sxt_s = sync_ff[3];
   assign sirc_s = sync_ff[4];
   assign frdy_s = sync_ff[5];
   assign sfast_s = sync_ff[7:6];
   assign sslow_s = sync_ff[8];

   // nominal-rate sources
   // Sampling at 40 MHz keeps edges of the 8 MHz and slower sources.
   always_comb
   begin
      unique case (sfast_s)
         scm_pkg::CFG_FAST_XTAL: fast_lvl = fxt_s;
         scm_pkg::CFG_FAST_EXT_RC: fast_lvl = ferc_s;
         default: fast_lvl = firc_s;
      endcase
      sub_lvl = (sslow_s == scm_pkg::CFG_SLOW_XTAL) ? sxt_s : sirc_s;
   end

   scm_fast_div #(.W(DW)) u_div (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .fast_lvl(fast_lvl),
      .div_ff(div_ff)
   );

   // Register writes; reserved bits are dropped
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_sel_ff <= scm_pkg::MODE_CTRL_RST[scm_pkg::DIV_SEL_HI:
                                              scm_pkg::DIV_SEL_LO];
         idle_en_ff <= scm_pkg::MODE_CTRL_RST[scm_pkg::IDLE_EN_BIT];
         hl_sel_ff <= scm_pkg::MODE_CTRL_RST[scm_pkg::HL_SEL_BIT];
         keep_on_ff <= scm_pkg::MODE_EXT_RST[scm_pkg::KEEP_ON_BIT];
         lxt_lp_ff <= scm_pkg::LXT_PWR_RST[scm_pkg::LXT_LP_BIT];
      end
      else if (reg_wr)
      begin
         if (reg_addr == scm_pkg::OFS_MODE_CTRL)
         begin
            div_sel_ff <= reg_wdata[scm_pkg::DIV_SEL_HI:
                                    scm_pkg::DIV_SEL_LO];
            idle_en_ff <= reg_wdata[scm_pkg::IDLE_EN_BIT];
            hl_sel_ff <= reg_wdata[scm_pkg::HL_SEL_BIT];
         end
         if (reg_addr == scm_pkg::OFS_MODE_EXT)
         begin
            keep_on_ff <= reg_wdata[scm_pkg::KEEP_ON_BIT];
         end
         if (reg_addr == scm_pkg::OFS_LXT_PWR)
         begin
            lxt_lp_ff <= reg_wdata[scm_pkg::LXT_LP_BIT];
         end
      end
   end

   // Read data stand one cycle after the strobe; unmapped reads give 0
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_ff <= 8'h00;
      end
      else if (reg_rd)
      begin
         rdata_ff <= 8'h00;
         unique case (reg_addr)
            scm_pkg::OFS_MODE_CTRL:
            begin
               rdata_ff[scm_pkg::DIV_SEL_HI:scm_pkg::DIV_SEL_LO] <=
                  div_sel_ff;
               rdata_ff[scm_pkg::IDLE_EN_BIT] <= idle_en_ff;
               rdata_ff[scm_pkg::HL_SEL_BIT] <= hl_sel_ff;
            end
            scm_pkg::OFS_MODE_EXT:
               rdata_ff[scm_pkg::KEEP_ON_BIT] <= keep_on_ff;
            scm_pkg::OFS_LXT_PWR:
               rdata_ff[scm_pkg::LXT_LP_BIT] <= lxt_lp_ff;
            scm_pkg::OFS_STATUS:
            begin
               rdata_ff[2:0] <= mode_ff;
               rdata_ff[scm_pkg::STAT_RUN_BIT] <= cpu_run_ff;
            end
            default:
               rdata_ff <= 8'h00;
         endcase
      end
   end

   always_comb
   begin
      if (hl_sel_ff)
      begin
         run_mode = scm_pkg::MODE_NORMAL;
         sel_code = scm_pkg::SRC_FAST;
      end
      else if (div_sel_ff > scm_pkg::DIV_SUB_MAX)
      begin
         run_mode = scm_pkg::MODE_NORMAL;
         sel_code = {scm_pkg::SRC_DIV_FLAG, div_sel_ff};
      end
      else
      begin
         run_mode = scm_pkg::MODE_SLOW;
         sel_code = scm_pkg::SRC_SUB;
      end
   end

   // idle choice on halt
   // Sleep keeps the substitute clock when watchdog or detector need it.
   always_comb
   begin
      if (idle_en_ff)
      begin
         halt_mode = keep_on_ff ? scm_pkg::MODE_IDLE_CLOCK_RUN
                                : scm_pkg::MODE_IDLE_ALL_STOP;
      end
      else
      begin
         halt_mode = sub_keep_req ? scm_pkg::MODE_SLEEP_SUB_ON
                                  : scm_pkg::MODE_SLEEP_ALL_OFF;
      end
   end

   always_comb
   begin
      nxt_mode = mode_ff;
      unique case (mode_ff)
         scm_pkg::MODE_NORMAL, scm_pkg::MODE_SLOW:
            nxt_mode = halt_req ? halt_mode : run_mode;
         // substitute clock until fast is ready
         scm_pkg::MODE_WAKE_SUB:
         begin
            if (halt_req)
               nxt_mode = halt_mode;
            else if (frdy_s || run_mode == scm_pkg::MODE_SLOW)
               nxt_mode = run_mode;
         end
         scm_pkg::MODE_IDLE_ALL_STOP, scm_pkg::MODE_SLEEP_SUB_ON:
         begin
            if (wake_req)
               nxt_mode = (run_mode == scm_pkg::MODE_NORMAL)
                          ? scm_pkg::MODE_WAKE_SUB : run_mode;
         end
         scm_pkg::MODE_IDLE_CLOCK_RUN, scm_pkg::MODE_SLEEP_ALL_OFF:
         begin
            if (wake_req)
               nxt_mode = run_mode;
         end
         default:
            nxt_mode = scm_pkg::MODE_NORMAL;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_ff <= scm_pkg::MODE_NORMAL;
      end
      else
      begin
         mode_ff <= nxt_mode;
      end
   end

   // fast clock, divided or undivided, in full speed
   always_comb
   begin
      unique case (mode_ff)
         scm_pkg::MODE_NORMAL, scm_pkg::MODE_IDLE_CLOCK_RUN:
            nxt_req = sel_code;
         scm_pkg::MODE_SLOW, scm_pkg::MODE_WAKE_SUB:
            nxt_req = scm_pkg::SRC_SUB;
         default:
            nxt_req = scm_pkg::SRC_OFF;
      endcase
      sub_on = (mode_ff != scm_pkg::MODE_SLEEP_ALL_OFF);
      fast_on = (mode_ff == scm_pkg::MODE_NORMAL) ||
                (mode_ff == scm_pkg::MODE_WAKE_SUB) ||
                (mode_ff == scm_pkg::MODE_IDLE_CLOCK_RUN &&
                 run_mode == scm_pkg::MODE_NORMAL);
   end

   function automatic logic src_lvl(input logic [3:0] code,
                                    input logic sub,
                                    input logic fast,
                                    input logic [DW-1:0] div);
      logic [2:0] idx;
      idx = 3'(3'h7 - code[2:0]);
      if (code[3] == scm_pkg::SRC_DIV_FLAG)
         src_lvl = div[idx];
      else if (code == scm_pkg::SRC_FAST)
         src_lvl = fast;
      else if (code == scm_pkg::SRC_SUB)
         src_lvl = sub;
      else
         src_lvl = 1'b0;
   endfunction : src_lvl

   assign sel_if.req_code = nxt_req;
   assign sel_if.req_lvl = src_lvl(nxt_req, sub_lvl, fast_lvl, div_ff);
   assign sel_if.cur_lvl = src_lvl(sel_if.cur_code, sub_lvl, fast_lvl,
                                   div_ff);

   scm_glitch_mux u_mux (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .sel(sel_if.mux),
      .clk_ff(mux_clk_ff)
   );

   // Outputs registered; clocks lag their sources by a few cycles
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sys_out_ff <= 1'b0;
         sub_out_ff <= 1'b0;
         cpu_run_ff <= 1'b0;
         fast_en_ff <= 3'h0;
         sxt_en_ff <= 1'b0;
         sirc_en_ff <= 1'b0;
      end
      else
      begin
         sys_out_ff <= mux_clk_ff;
         // substitute clock to timebase and watchdog
         sub_out_ff <= sub_on & sub_lvl;
         cpu_run_ff <= (mode_ff == scm_pkg::MODE_NORMAL) ||
                       (mode_ff == scm_pkg::MODE_SLOW) ||
                       (mode_ff == scm_pkg::MODE_WAKE_SUB);
         fast_en_ff <= 3'h0;
         fast_en_ff[sfast_s == scm_pkg::CFG_FAST_XTAL ? 0 :
                    sfast_s == scm_pkg::CFG_FAST_EXT_RC ? 1 : 2] <= fast_on;
         sxt_en_ff <= sub_on && sslow_s == scm_pkg::CFG_SLOW_XTAL;
         sirc_en_ff <= sub_on && sslow_s == scm_pkg::CFG_SLOW_INT_RC;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pb1_ff <= 1'b0;
         pb2_ff <= 1'b0;
         xt_free_ff <= 1'b0;
      end
      else
      begin
         pb1_ff <= (sfast_s != scm_pkg::CFG_FAST_XTAL) &&
                   (sfast_s != scm_pkg::CFG_FAST_EXT_RC);
         pb2_ff <= (sfast_s != scm_pkg::CFG_FAST_XTAL);
         xt_free_ff <= (sslow_s != scm_pkg::CFG_SLOW_XTAL);
      end
   end

   assign reg_rdata = rdata_ff;
   assign system_clock_out = sys_out_ff;
   assign sub_clock_out = sub_out_ff;
   assign cpu_run = cpu_run_ff;
   assign op_mode = mode_ff;
   assign fast_osc_en = fast_en_ff;
   assign slow_crystal_en = sxt_en_ff;
   assign slow_rc_en = sirc_en_ff;
   // low power select drives the crystal
   assign slow_crystal_power_sel = lxt_lp_ff;
   assign pb1_gpio_free = pb1_ff;
   assign pb2_gpio_free = pb2_ff;
   assign xt_pins_gpio_free = xt_free_ff;
endmodule : scm_top

//--- tb/scm_top_props.sv
// Port-level checks of the clock mode control block
`timescale 1ns/1ps
module scm_top_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [1:0] cfg_fast_src,
   input wire logic halt_req,
   input wire logic wake_req,
   input wire logic sub_clock_out,
   input wire logic cpu_run,
   input wire logic [2:0] op_mode,
   input wire logic [2:0] fast_osc_en,
   input wire logic slow_crystal_power_sel,
   input wire logic pb1_gpio_free,
   input wire logic pb2_gpio_free
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_power_follow: assert property (
      reg_wr && reg_addr == scm_pkg::OFS_LXT_PWR |=>
      {7'h00, slow_crystal_power_sel} == ($past(reg_wdata) & 8'h01))
      else $error("power select differs from written bit");
   a_power_reset: assert property (
      $rose(rst_n) |-> !slow_crystal_power_sel)
      else $error("power select set after reset");
   a_power_rsvd: assert property (
      reg_rd && reg_addr == scm_pkg::OFS_LXT_PWR |=> reg_rdata[7:1] == 7'h00)
      else $error("power register upper bits not zero");
   a_cpu_run_mode: assert property (
      $past(rst_n) |->
      cpu_run == ($past(op_mode) inside {3'h0, 3'h1, 3'h6}))
      else $error("cpu run disagrees with mode");
   // Middle sample of a long slow stretch, so entry and exit skew is harmless
   a_slow_fast_off: assert property (
      (op_mode == 3'h1) [*6] |-> $past(fast_osc_en, 3) == 3'h0)
      else $error("fast oscillator enabled in slow mode");
   a_sleep_sub_off: assert property (
      (op_mode == 3'h4) [*5] |-> $past(sub_clock_out, 2) == 1'b0)
      else $error("substitute clock runs in full sleep");
   a_pin_release: assert property (
      ($stable(cfg_fast_src) && $past(rst_n)) [*4] |->
      pb1_gpio_free == cfg_fast_src[1] &&
      pb2_gpio_free == (cfg_fast_src != 2'h0))
      else $error("oscillator pin release wrong");
   a_halt_enter: assert property (
      halt_req && op_mode inside {3'h0, 3'h1, 3'h6} |=>
      op_mode inside {[3'h2:3'h5]})
      else $error("halt did not stop the processor");
   a_wake_exit: assert property (
      wake_req && op_mode inside {[3'h2:3'h5]} |=>
      op_mode inside {3'h0, 3'h1, 3'h6})
      else $error("wake did not resume the processor");
endmodule : scm_top_props

bind scm_top scm_top_props i_props (.sys_clk(sys_clk), .rst_n(rst_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_fast_src(cfg_fast_src),
   .halt_req(halt_req), .wake_req(wake_req), .sub_clock_out(sub_clock_out),
   .cpu_run(cpu_run), .op_mode(op_mode), .fast_osc_en(fast_osc_en),
   .slow_crystal_power_sel(slow_crystal_power_sel),
   .pb1_gpio_free(pb1_gpio_free), .pb2_gpio_free(pb2_gpio_free));

//--- tb/tb_scm_top.sv
// Self-checking bench of the system clock mode control block
`timescale 1ns/1ps
`define SCM_CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         n_errors++; \
         $display("unexpected %s: expected %h, seen %h", what, exp, got); \
      end \
   end
module tb_scm_top;
   logic sys_clk, rst_n, reg_wr, reg_rd, halt_req, wake_req, sub_keep_req;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
   logic f_xt, f_erc, f_irc, s_xt, s_rc, fast_osc_ready, cfg_slow_src;
   logic [1:0] cfg_fast_src;
   logic system_clock_out, sub_clock_out, cpu_run, slow_crystal_en;
   logic slow_rc_en, slow_crystal_power_sel, pb1_gpio_free, pb2_gpio_free;
   logic xt_pins_gpio_free, sco_q, sbo_q;
   logic [2:0] op_mode, fast_osc_en;
   logic [10:0] row;
   int n_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   int ph = 1000;
   int min_ph = 1000;
   int last_rise = 0;
   int rise_gap = 0;
   int n_sys = 0;
   int n_sub = 0;
   int rdy_cnt = 0;
   int old, per, s0, b0;
   localparam logic [7:0] RST_EXP [5] = '{8'h03, 8'h00, 8'h00, 8'h08, 8'h00};
   // Idle en, keep on, keep req, mode, sys runs, sub runs, wake mode (7 any)
   localparam logic [10:0] HALT_ROW [4] = '{11'h44e, 11'h67f, 11'h087,
      11'h1ae};
   localparam int FAST_PER [3] = '{8, 12, 16};

   scm_top i_dut (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .fast_crystal_osc(f_xt),
      .fast_external_rc_osc(f_erc), .fast_internal_rc_osc(f_irc),
      .slow_crystal_osc(s_xt), .slow_internal_rc_osc(s_rc),
      .fast_osc_ready(fast_osc_ready), .cfg_fast_src(cfg_fast_src),
      .cfg_slow_src(cfg_slow_src), .halt_req(halt_req), .wake_req(wake_req),
      .sub_keep_req(sub_keep_req), .system_clock_out(system_clock_out),
      .sub_clock_out(sub_clock_out), .cpu_run(cpu_run), .op_mode(op_mode),
      .fast_osc_en(fast_osc_en), .slow_crystal_en(slow_crystal_en),
      .slow_rc_en(slow_rc_en),
      .slow_crystal_power_sel(slow_crystal_power_sel),
      .pb1_gpio_free(pb1_gpio_free), .pb2_gpio_free(pb2_gpio_free),
      .xt_pins_gpio_free(xt_pins_gpio_free)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Offset so oscillator edges never meet a clock edge: periods stay exact
   initial
   begin
      {f_xt, f_erc, f_irc, s_xt, s_rc} = 5'h00;
      #3;
      fork
         forever #100 f_xt = ~f_xt;
         forever #150 f_erc = ~f_erc;
         forever #200 f_irc = ~f_irc;
         forever #1000 s_xt = ~s_xt;
         forever #1250 s_rc = ~s_rc;
      join
   end
   // Fast oscillator reports stable only 20 cycles after being enabled
   always @(negedge sys_clk)
      rdy_cnt <= (fast_osc_en == 3'h0) ? 0 : (rdy_cnt < 20 ? rdy_cnt + 1 : 20);
   assign fast_osc_ready = (rdy_cnt == 20);

   always @(negedge sys_clk)
   begin
      cyc <= cyc + 1;
      sco_q <= system_clock_out;
      sbo_q <= sub_clock_out;
      if (sub_clock_out !== sbo_q)
         n_sub <= n_sub + 1;
      if (!rst_n)
         ph <= 1000;
      else if (system_clock_out !== sco_q)
      begin
         n_sys <= n_sys + 1;
         ph <= 1;
         if (ph < min_ph)
            min_ph <= ph;
         if (system_clock_out)
         begin
            rise_gap <= cyc - last_rise;
            last_rise <= cyc;
         end
      end
      else
         ph <= ph + 1;
   end

   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
   endtask : do_reset

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      rd_val = reg_rdata;
   endtask : rd

   task automatic pulse(input bit wake);
      @(posedge sys_clk);
      if (wake)
         wake_req <= 1'b1;
      else
         halt_req <= 1'b1;
      @(posedge sys_clk);
      wake_req <= 1'b0;
      halt_req <= 1'b0;
      @(negedge sys_clk);
   endtask : pulse

   task automatic complete_run();
      if (n_errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run

   // The tests need about 7200 cycles
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      complete_run();
   end

   initial
   begin
      rst_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      halt_req = 1'b0;
      wake_req = 1'b0;
      sub_keep_req = 1'b0;
      cfg_fast_src = 2'h0;
      cfg_slow_src = 1'b1;
      // Each source option from power-on; ends on the crystal options
      for (int c = 2; c >= 0; c--)
      begin
         cfg_fast_src <= 2'(c);
         cfg_slow_src <= (c != 1);
         do_reset();
         repeat (4 * FAST_PER[c] + 40) @(negedge sys_clk);
         `SCM_CHK("pb1 free", (c == 2), pb1_gpio_free)
         `SCM_CHK("pb2 free", (c != 0), pb2_gpio_free)
         `SCM_CHK("xt pins free", (c == 1), xt_pins_gpio_free)
         `SCM_CHK("slow rc enable", (c == 1), slow_rc_en)
         `SCM_CHK("fast enable", 3'h1 << c, fast_osc_en)
         `SCM_CHK("undivided period", FAST_PER[c], rise_gap)
      end
      for (int a = 0; a < 5; a++)
      begin
         rd(8'(a));
         `SCM_CHK("reset value", RST_EXP[a], rd_val)
      end
      rd(8'hff);
      `SCM_CHK("unmapped read", 8'h00, rd_val)
      wr(scm_pkg::OFS_LXT_PWR, 8'hff);
      rd(scm_pkg::OFS_LXT_PWR);
      `SCM_CHK("power register", 8'h01, rd_val)
      `SCM_CHK("power select", 1'b1, slow_crystal_power_sel)
      `SCM_CHK("crystal enable", 1'b1, slow_crystal_en)
      wr(8'h04, 8'h00);
      wr(scm_pkg::OFS_MODE_EXT, 8'hff);
      rd(scm_pkg::OFS_MODE_EXT);
      `SCM_CHK("ext register", 8'h80, rd_val)
      rd(scm_pkg::OFS_LXT_PWR);
      `SCM_CHK("power kept", 8'h01, rd_val)
      wr(scm_pkg::OFS_LXT_PWR, 8'h00);
      @(negedge sys_clk);
      `SCM_CHK("quick start", 1'b0, slow_crystal_power_sel)
      old = FAST_PER[0];
      for (int k = 0; k < 8; k++)
      begin
         per = (k < 2) ? 80 : (8 << (8 - k));
         wr(scm_pkg::OFS_MODE_CTRL, {3'(k), 5'h02});
         repeat (old + 3 * per + 60) @(negedge sys_clk);
         old = per;
         `SCM_CHK("divided period", per, rise_gap)
         `SCM_CHK("run mode", (k < 2) ? 3'h1 : 3'h0, op_mode)
         `SCM_CHK("fast on", (k < 2) ? 3'h0 : 3'h1, fast_osc_en)
      end
      for (int r = 0; r < 4; r++)
      begin
         row = HALT_ROW[r];
         pulse(1'b1);
         `SCM_CHK("wake while running", 3'h0, op_mode)
         wr(scm_pkg::OFS_MODE_EXT, {row[9], 7'h00});
         wr(scm_pkg::OFS_MODE_CTRL, {6'h38, row[10], 1'b1});
         sub_keep_req <= row[8];
         pulse(1'b0);
         `SCM_CHK("halt mode", row[7:5], op_mode)
         @(negedge sys_clk);
         `SCM_CHK("cpu halted", 1'b0, cpu_run)
         pulse(1'b0);
         `SCM_CHK("halt when halted", row[7:5], op_mode)
         // Let the switch finish its last phase before counting edges
         repeat (20) @(negedge sys_clk);
         s0 = n_sys;
         b0 = n_sub;
         repeat (300) @(negedge sys_clk);
         `SCM_CHK("system clock runs", row[4], n_sys != s0)
         `SCM_CHK("sub clock runs", row[3], n_sub != b0)
         pulse(1'b1);
         if (row[2:0] != 3'h7)
            `SCM_CHK("wake mode", row[2:0], op_mode)
         repeat (100) @(negedge sys_clk);
         `SCM_CHK("resumed mode", 3'h0, op_mode)
         `SCM_CHK("cpu resumed", 1'b1, cpu_run)
      end
      `SCM_CHK("shortest phase ok", 1'b1, min_ph >= 4)
      complete_run();
   end
endmodule : tb_scm_top
